// File: rtl/sspc_top.sv
// Serial port control/status with a four-wire shift engine.
// Assumes a one-cycle-read register port and pins sampled from outside.
`timescale 1ns/1ps
// Operation
// - Buffer write mid-transfer sets collision flag
// - Four-wire slave byte into full buffer sets overflow
// - Overflowed byte is dropped, buffer kept
// - Overflow only possible in slave operation
// - Two-wire received byte into full buffer sets overflow
// - Enable hands clock and data pins to port
// - Enable hands two-wire pins; clear releases them
// - Polarity one idles high, samples rising
// - Polarity zero idles low, samples falling
// - Two-wire polarity zero stretches clock low
// - Codes 0-2 master at divide 4/16/64
// - Code 3 master clocked by timer/2
// - Code 4 slave with select input
// - Code 5 slave, select pin ignored
// - Codes 6,7 two-wire slave 7/10-bit
// - Code B firmware two-wire master, slave idle
// - Codes E,F two-wire slave with start/stop
// - Direction bit holds last address match direction
// - Status top bits zero; control resets zero
// - Full byte loads buffer, sets full, interrupt
// - Ignored buffer write during transfer flags collision
// - Shift most significant bit first via buffer
module sspc_top (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   input  wire logic       tmr_pulse,
   input  wire logic       sck_in,
   output logic            sck_out,
   output logic            sck_oe_b,
   input  wire logic       sdi_in,
   output logic            sdo_out,
   output logic            sdo_oe_b,
   input  wire logic       ss_b_in,
   input  wire logic       tw_byte_done,
   input  wire logic [7:0] tw_byte,
   input  wire logic       tw_addr_match,
   input  wire logic       tw_dir_read,
   input  wire logic       tw_transmit,
   output logic            port_interrupt_flag,
   output logic            serial_pins_owned,
   output logic            tw_pins_owned,
   output logic            tw_clock_hold,
   output logic            tw_slave_active,
   output logic            tw_ten_bit,
   output logic            tw_start_stop_irq
);
   typedef struct packed {
      logic [7:0]            ctrl;
      logic [7:0]            buf_q;
      logic [7:0]            sr;
      logic [2:0]            bitn;
      sspc_pkg::sspc_phase_t ph;
      logic                  bf;
      logic                  rw;
      logic                  irq;
      logic                  pend;
      logic [2:0]            sck_s;
      logic [2:0]            sdi_s;
      logic [2:0]            ss_s;
      logic                  sck_seen;
      logic                  sck_o;
      logic                  sdo_o;
      logic [7:0]            rdata;
   } sspc_st_t;

   sspc_st_t    s_r;
   sspc_st_t    s_nxt;
   sspc_tick_if tk ();

   logic [3:0] mode;
   logic       en;
   logic       clock_polarity;
   logic       four_w;
   logic       master;
   logic       slave;
   logic       two_w;
   logic       sck_lvl;
   logic       sdi_lvl;
   logic       ss_act;
   logic       lead_edge;
   logic       trail_edge;
   logic       busy;
   logic       buf_wr;
   logic       buf_rd;

   // Mode decode
   always_comb begin
      mode   = s_r.ctrl[3:0];
      en     = s_r.ctrl[sspc_pkg::SSPC_CTRL_EN];
      clock_polarity    = s_r.ctrl[sspc_pkg::SSPC_CTRL_CKP];
      master = (mode <= sspc_pkg::SSPC_M_TMR);
      slave  = (mode == sspc_pkg::SSPC_M_SLV_SS) || (mode == sspc_pkg::SSPC_M_SLV);
      four_w = master || slave;
      two_w  = (mode == sspc_pkg::SSPC_M_I7) || (mode == sspc_pkg::SSPC_M_I10)
               || (mode == sspc_pkg::SSPC_M_IFW) || (mode == sspc_pkg::SSPC_M_I7SP)
               || (mode == sspc_pkg::SSPC_M_I10SP);
   end

   // Clock level counts once second and third stage agree; data takes the third stage alone
   always_comb begin
      sck_lvl = (s_r.sck_s[2] == s_r.sck_s[1]) ? s_r.sck_s[1] : s_r.sck_seen;
      sdi_lvl = s_r.sdi_s[2];
      // Select honoured in every code but 5; code 5 leaves the pin free
      ss_act  = (mode == sspc_pkg::SSPC_M_SLV) ? 1'b1 :
                !(s_r.ss_s[2] && s_r.ss_s[1]);
   end

   assign tk.run       = en && master && (s_r.ph != sspc_pkg::SSPC_IDLE);
   assign tk.mode      = mode;
   assign tk.tmr_pulse = tmr_pulse;

   sspc_div u_div (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .tk      (tk.div)
   );

   always_comb begin
      busy       = (s_r.ph != sspc_pkg::SSPC_IDLE) || (slave && s_r.bitn != 3'h0);
      buf_wr     = reg_wr && (reg_addr == sspc_pkg::SSPC_BUF_OFS);
      buf_rd     = reg_rd && (reg_addr == sspc_pkg::SSPC_BUF_OFS);
      // Leading edge shifts out, trailing edge samples; polarity picks direction
      if (slave) begin
         lead_edge  = ss_act && (sck_lvl != s_r.sck_seen) && (sck_lvl == !clock_polarity);
         trail_edge = ss_act && (sck_lvl != s_r.sck_seen) && (sck_lvl == clock_polarity);
      end else begin
         lead_edge  = tk.tick && (s_r.ph == sspc_pkg::SSPC_LEAD);
         trail_edge = tk.tick && (s_r.ph == sspc_pkg::SSPC_TRAIL);
      end
   end

   // Next-state logic
   always_comb begin
      s_nxt          = s_r;
      s_nxt.irq      = 1'b0;
      s_nxt.sck_s    = {s_r.sck_s[1:0], sck_in};
      s_nxt.sdi_s    = {s_r.sdi_s[1:0], sdi_in};
      s_nxt.ss_s     = {s_r.ss_s[1:0], ss_b_in};
      s_nxt.sck_seen = sck_lvl;
      s_nxt.rdata    = 8'h00;

      // Register reads; unmapped offsets read zero
      if (reg_rd) begin
         if (reg_addr == sspc_pkg::SSPC_CTRL_OFS) begin
            s_nxt.rdata = s_r.ctrl;
         end else if (reg_addr == sspc_pkg::SSPC_STAT_OFS) begin
            s_nxt.rdata = {2'b00, 3'b000, s_r.rw, 1'b0, s_r.bf};
         end else if (reg_addr == sspc_pkg::SSPC_BUF_OFS) begin
            s_nxt.rdata = s_r.buf_q;
         end
      end
      if (buf_rd) begin
         s_nxt.bf = 1'b0;
      end

      // Control write; flags only cleared by software writing zero
      if (reg_wr && reg_addr == sspc_pkg::SSPC_CTRL_OFS) begin
         s_nxt.ctrl = reg_wdata;
      end

      // Disable idles the engine and parks the clock at its idle level
      if (!en || !four_w) begin
         s_nxt.ph    = sspc_pkg::SSPC_IDLE;
         s_nxt.bitn  = 3'h0;
         s_nxt.sck_o = clock_polarity;
      end else begin
         if (s_r.ph == sspc_pkg::SSPC_IDLE) begin
            s_nxt.sck_o = clock_polarity;
         end
         // Buffer write: accepted when idle, else collision
         if (buf_wr) begin
            if (busy) begin
               s_nxt.ctrl[sspc_pkg::SSPC_CTRL_WRITE_COLLISION_FLAG] = 1'b1;
            end else begin
               s_nxt.sr    = reg_wdata;
               s_nxt.sdo_o = reg_wdata[7];
               s_nxt.bitn  = 3'h0;
               s_nxt.pend  = 1'b0;
               if (master) begin
                  s_nxt.ph = sspc_pkg::SSPC_LEAD;
               end
            end
         end
         if (lead_edge) begin
            if (master) begin
               s_nxt.sck_o = !clock_polarity;
               s_nxt.ph    = sspc_pkg::SSPC_TRAIL;
            end
            if (s_r.pend) begin
               s_nxt.sdo_o = s_r.sr[7];
               s_nxt.pend  = 1'b0;
            end
         end
         if (trail_edge) begin
            s_nxt.sr   = {s_r.sr[6:0], sdi_lvl};
            s_nxt.pend = 1'b1;
            s_nxt.bitn = s_r.bitn + 3'h1;
            if (master) begin
               s_nxt.sck_o = clock_polarity;
               s_nxt.ph    = (s_r.bitn == sspc_pkg::SSPC_LAST_BIT) ? sspc_pkg::SSPC_IDLE : sspc_pkg::SSPC_LEAD;
            end
            if (s_r.bitn == sspc_pkg::SSPC_LAST_BIT) begin
               s_nxt.irq  = 1'b1;
               s_nxt.bitn = 3'h0;
               if (s_r.bf && !buf_rd && slave) begin
                  // Byte in shifter is lost; buffer untouched
                  s_nxt.ctrl[sspc_pkg::SSPC_CTRL_OV] = 1'b1;
               end else begin
                  s_nxt.buf_q = {s_r.sr[6:0], sdi_lvl};
                  s_nxt.bf    = 1'b1;
               end
            end
         end
      end

      // Two-wire engine hands in bytes; this block keeps buffer and flags
      if (en && two_w && mode != sspc_pkg::SSPC_M_IFW) begin
         if (tw_addr_match) begin
            s_nxt.rw = tw_dir_read;
         end
         if (tw_byte_done) begin
            s_nxt.irq = 1'b1;
            if (s_r.bf && !buf_rd && !tw_transmit) begin
               s_nxt.ctrl[sspc_pkg::SSPC_CTRL_OV] = 1'b1;
            end else begin
               s_nxt.buf_q = tw_byte;
               s_nxt.bf    = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_r          <= '0;
         s_r.ctrl     <= sspc_pkg::SSPC_CTRL_RST;
         s_r.buf_q    <= sspc_pkg::SSPC_BYTE_RST;
         s_r.sck_s    <= 3'b000;
         s_r.ss_s     <= 3'b111;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Registered pin and status outputs
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         reg_rdata           <= 8'h00;
         sck_out             <= 1'b0;
         sck_oe_b            <= 1'b1;
         sdo_out             <= 1'b0;
         sdo_oe_b            <= 1'b1;
         port_interrupt_flag <= 1'b0;
         serial_pins_owned   <= 1'b0;
         tw_pins_owned       <= 1'b0;
         tw_clock_hold       <= 1'b0;
         tw_slave_active     <= 1'b0;
         tw_ten_bit          <= 1'b0;
         tw_start_stop_irq   <= 1'b0;
      end else begin
         reg_rdata           <= s_nxt.rdata;
         sck_out             <= s_nxt.sck_o;
         sck_oe_b            <= !(s_nxt.ctrl[5] && (s_nxt.ctrl[3:0] <= sspc_pkg::SSPC_M_TMR));
         sdo_out             <= s_nxt.sdo_o;
         sdo_oe_b            <= !(en && four_w && ss_act);
         port_interrupt_flag <= s_nxt.irq;
         serial_pins_owned   <= en && four_w;
         tw_pins_owned       <= en && two_w;
         tw_clock_hold       <= en && two_w && !clock_polarity;
         tw_slave_active     <= en && two_w && mode != sspc_pkg::SSPC_M_IFW;
         tw_ten_bit          <= (mode == sspc_pkg::SSPC_M_I10) || (mode == sspc_pkg::SSPC_M_I10SP);
         tw_start_stop_irq   <= en && (mode == sspc_pkg::SSPC_M_I7SP || mode == sspc_pkg::SSPC_M_I10SP);
      end
   end
endmodule // sspc_top

// File: rtl/sspc_pkg.sv
// Package for the serial port control and status block.
// Assumes a byte-wide register port; offsets are byte addresses.
package sspc_pkg;
   // Register offsets
   localparam logic [7:0] SSPC_CTRL_OFS   = 8'h14;
   localparam logic [7:0] SSPC_STAT_OFS   = 8'h94;
   localparam logic [7:0] SSPC_BUF_OFS    = 8'h13;
   localparam logic [7:0] SSPC_TMRCFG_OFS = 8'h15;
   // Control field positions
   localparam int SSPC_CTRL_WRITE_COLLISION_FLAG = 7;
   localparam int SSPC_CTRL_OV   = 6;
   localparam int SSPC_CTRL_EN   = 5;
   localparam int SSPC_CTRL_CKP  = 4;
   // Status field positions
   localparam int SSPC_STAT_RW   = 2;
   localparam int SSPC_STAT_UA   = 1;
   localparam int SSPC_STAT_BF   = 0;
   // Reset values
   localparam logic [7:0] SSPC_CTRL_RST = 8'h00;
   localparam logic [7:0] SSPC_BYTE_RST = 8'h00;
   // Mode field codes
   localparam logic [3:0] SSPC_M_DIV4   = 4'h0;
   localparam logic [3:0] SSPC_M_DIV16  = 4'h1;
   localparam logic [3:0] SSPC_M_DIV64  = 4'h2;
   localparam logic [3:0] SSPC_M_TMR    = 4'h3;
   localparam logic [3:0] SSPC_M_SLV_SS = 4'h4;
   localparam logic [3:0] SSPC_M_SLV    = 4'h5;
   localparam logic [3:0] SSPC_M_I7     = 4'h6;
   localparam logic [3:0] SSPC_M_I10    = 4'h7;
   localparam logic [3:0] SSPC_M_IFW    = 4'hB;
   localparam logic [3:0] SSPC_M_I7SP   = 4'hE;
   localparam logic [3:0] SSPC_M_I10SP  = 4'hF;
   // Half-bit terminal counts, half bit lasting count plus one system clocks: oscillator divided by 4, 16, 64
   localparam logic [5:0] SSPC_HALF_DIV4  = 6'h01;
   localparam logic [5:0] SSPC_HALF_DIV16 = 6'h07;
   localparam logic [5:0] SSPC_HALF_DIV64 = 6'h1F;
   localparam logic [2:0] SSPC_LAST_BIT   = 3'h7;
   typedef enum logic [1:0] {SSPC_IDLE, SSPC_LEAD, SSPC_TRAIL} sspc_phase_t;
endpackage : sspc_pkg

// File: rtl/sspc_if.sv
// Interface between the serial port core and its edge tick divider.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface sspc_tick_if;
   logic       run;
   logic [3:0] mode;
   logic       tmr_pulse;
   logic       tick;
   modport core (output run, output mode, output tmr_pulse, input tick);
   modport div  (input run, input mode, input tmr_pulse, output tick);
endinterface : sspc_tick_if

// File: rtl/sspc_div.sv
// Half-bit tick generator for four-wire master modes.
// Assumes the timer pulse is a one-cycle enable on clk_sys.
`timescale 1ns/1ps
module sspc_div (
   input  wire logic    clk_sys,
   input  wire logic    rst_b,
   sspc_tick_if.div     tk
);
   typedef struct packed {
      logic [5:0] cnt;
      logic       tick;
   } sspc_div_st_t;
   sspc_div_st_t s_r;
   sspc_div_st_t s_nxt;
   logic [5:0]   lim;

   // Divide choice and count; timer mode halves each timer pulse pair
   always_comb begin
      s_nxt      = s_r;
      s_nxt.tick = 1'b0;
      case (tk.mode)
         sspc_pkg::SSPC_M_DIV16: lim = sspc_pkg::SSPC_HALF_DIV16;
         sspc_pkg::SSPC_M_DIV64: lim = sspc_pkg::SSPC_HALF_DIV64;
         default:                lim = sspc_pkg::SSPC_HALF_DIV4;
      endcase
      if (!tk.run) begin
         s_nxt.cnt = 6'h00;
      end else if (tk.mode == sspc_pkg::SSPC_M_TMR) begin
         // Timer output divided by two gives the bit clock; one tick per pulse
         s_nxt.tick = tk.tmr_pulse;
      end else if (s_r.cnt >= lim) begin
         s_nxt.cnt  = 6'h00;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 6'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tk.tick = s_r.tick;
endmodule // sspc_div

// File: tb/sspc_properties.sv
// Checker bound to the serial port top.
// Assumes it sees the top module's ports only.
`timescale 1ns/1ps
module sspc_properties (
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       sck_oe_b,
   input wire logic       port_interrupt_flag,
   input wire logic       serial_pins_owned,
   input wire logic       tw_pins_owned,
   input wire logic       tw_clock_hold,
   input wire logic       tw_slave_active,
   input wire logic       tw_ten_bit,
   input wire logic       tw_start_stop_irq
);
   logic [7:0] cfg_r; // Last control write
   logic [1:0] age_r; // Cycles since it, saturating
   wire  [3:0] md  = cfg_r[3:0];
   wire        en  = cfg_r[5];
   wire        twc = md inside {4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
   // Reserved codes are left unjudged; outputs may lag a write by two flops
   wire        ok  = (age_r == 2'h3) && (md <= 4'h5 || twc);
   wire        tw  = ok && en && twc;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // Mirror of software writes; hardware-set flags are not tracked
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cfg_r <= 8'h00;
         age_r <= 2'h0;
      end else if (reg_wr && reg_addr == sspc_pkg::SSPC_CTRL_OFS) begin
         cfg_r <= reg_wdata;
         age_r <= 2'h0;
      end else if (age_r != 2'h3) begin
         age_r <= age_r + 2'h1;
      end
   end
   sequence rd_at(a);
      reg_rd && reg_addr == a ##1 1'b1;
   endsequence
   chk_pins_four: assert property (ok |-> serial_pins_owned == (en && md <= 4'h5))
      else $error("four-wire pin ownership wrong");
   chk_pins_two: assert property (ok |-> tw_pins_owned == (en && twc))
      else $error("two-wire pin ownership wrong");
   chk_clk_drive: assert property (ok |-> sck_oe_b == !(en && md <= 4'h3))
      else $error("clock drive wrong for mode");
   chk_clk_hold: assert property (tw |-> tw_clock_hold == !cfg_r[4])
      else $error("clock stretch wrong");
   chk_ten_bit: assert property (tw && md != 4'hB |-> tw_ten_bit == md[0])
      else $error("address width wrong");
   chk_slave_idle: assert property (tw |-> tw_slave_active == (md != 4'hB))
      else $error("slave activity wrong");
   chk_start_stop: assert property (tw |-> tw_start_stop_irq == (md[3:2] == 2'h3))
      else $error("start stop enable wrong");
   chk_irq_pulse: assert property (port_interrupt_flag |=> !port_interrupt_flag)
      else $error("interrupt pulse too long");
   chk_stat_top: assert property (rd_at(sspc_pkg::SSPC_STAT_OFS) |-> reg_rdata[7:6] == 2'h0)
      else $error("status top bits set");
   chk_master_ovf: assert property (
      ok && en && md <= 4'h3 && !cfg_r[6] ##0 rd_at(sspc_pkg::SSPC_CTRL_OFS) |-> !reg_rdata[6])
      else $error("overflow in master mode");
endmodule // sspc_properties

bind sspc_top sspc_properties u_props (.*);

// File: tb/sspc_peer.sv
// Far-side serial device: slave to the port's master, master to its slave.
// Assumes the bench mirrors the polarity bit on clock_polarity.
`timescale 1ns/1ps
module sspc_peer (
   input  wire logic clk_sys,
   input  wire logic clock_polarity,
   input  wire logic sck_out,
   input  wire logic sdo_out,
   output logic      sck_in,
   output logic      sdi_in,
   output logic      ss_b_in
);
   logic [7:0] tx  = 8'h00; // Byte sent back
   logic [7:0] rx  = 8'h00; // Byte caught
   logic       own = 1'b0;  // Peer makes the clock
   initial begin
      sck_in = 1'b0;
      sdi_in = 1'b0;
      ss_b_in = 1'b1;
   end
   // As slave: catch and set up the next bit on the trailing edge
   // The port sees its data pin three flops late, so a bit set on the
   // leading edge would miss the sample at the fastest rate
   always @(sck_out) begin
      if (!own && sck_out == clock_polarity) begin
         rx <= {rx[6:0], sdo_out};
         sdi_in <= tx[6];
         tx <= {tx[6:0], ~tx[7]};
      end
   end
   // Clock rests at the idle level between frames
   always @(posedge clk_sys) begin
      if (!own) begin
         sck_in <= clock_polarity;
      end
   end
   // As master: eight-cycle half bits, select low over the byte
   task automatic drive(input logic [7:0] b);
      int i;
      own <= 1'b1;
      ss_b_in <= 1'b0;
      repeat (8) @(posedge clk_sys);
      for (i = 7; i >= 0; i--) begin
         sck_in <= ~clock_polarity;
         sdi_in <= b[i];
         repeat (8) @(posedge clk_sys);
         sck_in <= clock_polarity;
         rx <= {rx[6:0], sdo_out};
         repeat (8) @(posedge clk_sys);
      end
      ss_b_in <= 1'b1;
      sdi_in <= ~b[0]; // No stale bit after release
      own <= 1'b0;
      @(posedge clk_sys);
   endtask
endmodule // sspc_peer

// File: tb/tb_sync_serial_port_ctrl_status.sv
// Self-checking bench for the serial port control block.
// Assumes the sspc_peer model on the serial pins.
`timescale 1ns/1ps
module tb_sync_serial_port_ctrl_status;
   localparam logic [7:0] CTL = sspc_pkg::SSPC_CTRL_OFS;
   localparam logic [7:0] STA = sspc_pkg::SSPC_STAT_OFS;
   localparam logic [7:0] BUF = sspc_pkg::SSPC_BUF_OFS;
   logic       clk_sys = 1'b0;
   logic       rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] tw_byte = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       tmr_pulse = 1'b0;
   logic       tw_byte_done = 1'b0;
   logic       tw_addr_match = 1'b0;
   logic       tw_dir_read = 1'b0;
   logic       tw_transmit = 1'b0;
   logic       clock_polarity = 1'b0;
   logic [7:0] reg_rdata;
   logic       sck_out, sck_oe_b, sdo_out, sdo_oe_b, sck_in, sdi_in, ss_b_in;
   logic       port_interrupt_flag, serial_pins_owned, tw_pins_owned;
   logic       tw_clock_hold, tw_slave_active, tw_ten_bit, tw_start_stop_irq;
   logic [7:0] rv;
   int         fails = 0;
   int         checks = 0;
   int         tc = 0;
   sspc_top dut (.*);
   sspc_peer u_peer (.*);
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Timer stand-in: a pulse every fifth cycle
   always @(posedge clk_sys) begin
      tc <= (tc == 4) ? 0 : tc + 1;
      tmr_pulse <= (tc == 4);
   end
   task automatic end_sim();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // Bus cycles end with a spare edge so strobes never double up
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
      @(posedge clk_sys);
   endtask
   // Waits for the byte-done pulse, keeping the last clock half period
   task automatic wait_irq(output int h);
      int n;
      int t;
      logic q;
      n = 0;
      t = 0;
      h = 0;
      q = sck_out;
      while (port_interrupt_flag !== 1'b1 && n < 4000) begin
         @(posedge clk_sys);
         n++;
         t++;
         if (sck_out !== q) begin
            h = t;
            t = 0;
            q = sck_out;
         end
      end
      if (n >= 4000) begin
         fails++;
         end_sim();
      end
   endtask
   task automatic twp(input logic m, input logic [7:0] b);
      tw_byte <= b;
      tw_dir_read <= b[0];
      tw_addr_match <= m;
      tw_byte_done <= ~m;
      @(posedge clk_sys);
      tw_addr_match <= 1'b0;
      tw_byte_done <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic t_reset();
      rd(CTL, rv);
      cmp("ctrl", 8'h00, rv);
      rd(STA, rv);
      cmp("stat", 8'h00, rv);
      rd(8'h15, rv);
      cmp("spare", 8'h00, rv);
   endtask
   // Every master rate, with a second write landing mid-transfer
   task automatic t_master();
      logic [7:0] hx [4] = '{8'h02, 8'h08, 8'h20, 8'h05};
      int i;
      int h;
      for (i = 0; i < 4; i++) begin
         clock_polarity <= ~i[0];
         wr(CTL, {3'h1, ~i[0], i[3:0]});
         // Let the parked clock settle before loading the peer
         @(posedge clk_sys);
         u_peer.tx <= 8'hC3 ^ i[7:0];
         u_peer.sdi_in <= 1'b1; // First bit stands before the first edge
         wr(BUF, 8'h5A + i[7:0]);
         wr(BUF, 8'hFF);
         wait_irq(h);
         cmp("half", hx[i], h[7:0]);
         rd(STA, rv);
         cmp("full", 8'h01, rv & 8'h01);
         rd(BUF, rv);
         cmp("rx", 8'hC3 ^ i[7:0], rv);
         cmp("tx", 8'h5A + i[7:0], u_peer.rx);
         rd(STA, rv);
         cmp("drain", 8'h00, rv & 8'h01);
         rd(CTL, rv);
         cmp("write_collision_flag", 8'h80, rv & 8'hC0);
         cmp("idle", {7'h0, ~i[0]}, {7'h0, sck_out});
      end
   endtask
   task automatic t_slave();
      clock_polarity <= 1'b0;
      wr(CTL, 8'h25);
      wr(BUF, 8'h96);
      cmp("sdodrv", 8'h00, {7'h0, sdo_oe_b});
      u_peer.drive(8'hA5);
      cmp("sout", 8'h96, u_peer.rx);
      u_peer.drive(8'h3C);
      rd(CTL, rv);
      cmp("ovf", 8'h40, rv & 8'hC0);
      rd(BUF, rv);
      cmp("keep", 8'hA5, rv);
      wr(CTL, 8'h24);
      repeat (2) @(posedge clk_sys);
      cmp("sdooff", 8'h01, {7'h0, sdo_oe_b});
      u_peer.drive(8'h81);
      rd(BUF, rv);
      cmp("ssel", 8'h81, rv);
      rd(CTL, rv);
      cmp("noovf", 8'h00, rv & 8'hC0);
   endtask
   task automatic t_two();
      logic [3:0] cd [5] = '{4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
      int i;
      for (i = 0; i < 5; i++) begin
         wr(CTL, {3'h1, i[0], cd[i]});
         repeat (4) @(posedge clk_sys);
         cmp("twpin", 8'h01, {7'h0, tw_pins_owned});
      end
      wr(CTL, 8'h06);
      repeat (4) @(posedge clk_sys);
      cmp("free", 8'h00, {6'h0, tw_pins_owned, serial_pins_owned});
      wr(CTL, 8'h36);
      twp(1'b0, 8'h11);
      twp(1'b0, 8'h22);
      rd(CTL, rv);
      cmp("twovf", 8'h40, rv & 8'hC0);
      rd(BUF, rv);
      cmp("twkeep", 8'h11, rv);
      twp(1'b1, 8'h01);
      rd(STA, rv);
      cmp("dir", 8'h04, rv & 8'h04);
      twp(1'b1, 8'h00);
      rd(STA, rv);
      cmp("dir", 8'h00, rv & 8'h04);
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_master();
      t_slave();
      t_two();
      end_sim();
   end
endmodule // tb_sync_serial_port_ctrl_status
